// ===== inc/dsfcu_map.vh
`ifndef DSFCU_MAP_VH
`define DSFCU_MAP_VH

// ****************************************************************
// Frame geometry
// ****************************************************************
`define DSFCU_CNT_W          6
`define DSFCU_FRAME_BITS     6'd24
`define DSFCU_CRC_FRAME_BITS 6'd32
`define DSFCU_CRC_POLY       8'h07
`define DSFCU_RW_BIT         23
`define DSFCU_ADDR_MSB       22
`define DSFCU_ADDR_LSB       16
`define DSFCU_DATA_MSB       15
`define DSFCU_CRC_MSB        7

// ****************************************************************
// Register addresses
// ****************************************************************
`define DSFCU_ADDR_NOP       7'h00
`define DSFCU_ADDR_RESET     7'h01
`define DSFCU_ADDR_RSTCFG    7'h02
`define DSFCU_ADDR_SELECT    7'h03
`define DSFCU_ADDR_CONFIG    7'h04
`define DSFCU_ADDR_DATA      7'h05
`define DSFCU_ADDR_CALEN     7'h08
`define DSFCU_ADDR_GAIN      7'h09
`define DSFCU_ADDR_OFFSET    7'h0a
`define DSFCU_ADDR_STATUS    7'h0b

// ****************************************************************
// Field positions
// ****************************************************************
`define DSFCU_SW_RST_BIT     0
`define DSFCU_POC_BIT        1
`define DSFCU_CRC_CHECK_ENABLE_BIT       3
`define DSFCU_CH_LSB         5
`define DSFCU_CLSL_LSB       9
`define DSFCU_CRE_BIT        5
`define DSFCU_CALEN_BIT      0

// ****************************************************************
// Reset and clear values
// ****************************************************************
`define DSFCU_GAIN_RST       16'h8000
`define DSFCU_GAIN_BIAS      17'h08000
`define DSFCU_CLEAR_MID      16'h8000
`define DSFCU_CLEAR_ZERO     16'h0000
`define DSFCU_CODE_MAX       19'h0ffff
`define DSFCU_SELECT_MASK    16'h1fff
`define DSFCU_PIN_IDLE       5'h0b

`endif

// ===== design/dsfcu_crc8.v
`timescale 1ns/1ps

// ****************************************************************
// CRC-8, MSB first, zero seed
// ****************************************************************
`include "dsfcu_map.vh"

module dsfcu_crc8 #(
    parameter DW = 32
) (
    input  wire [DW-1:0] data_in,  // Bits, oldest in the MSB
    output reg  [7:0]    crc_out   // Remainder
);
    reg     [7:0] c;
    reg           fb;
    integer       i;

    // Bitwise long division; cheap at these widths
    always @* begin
        c  = 8'h00;
        fb = 1'b0;
        for (i = DW - 1; i >= 0; i = i - 1) begin
            fb = c[7] ^ data_in[i];
            c  = {c[6:0], 1'b0} ^ (fb ? `DSFCU_CRC_POLY : 8'h00);
        end
        crc_out = c;
    end
endmodule // dsfcu_crc8

// ===== design/dsfcu_cal.v
`timescale 1ns/1ps

// ****************************************************************
// Per-channel gain/offset trim and clear stage
// ****************************************************************
`include "dsfcu_map.vh"

module dsfcu_cal (
    input  wire        clock_in,     // System clock
    input  wire        rst_b_in,     // Async reset, active low
    input  wire [15:0] code_in,      // Latched converter code
    input  wire [15:0] gain_in,      // Unsigned gain trim
    input  wire [15:0] offset_in,    // Signed offset trim
    input  wire        cal_en_in,    // Trim active
    input  wire        clear_in,     // Force clear code
    input  wire        clear_mid_in, // Clear to midscale
    output reg  [15:0] code_out      // Final channel code
);
    wire        [16:0] gain_eff;
    wire        [32:0] prod;
    wire        [16:0] scaled;
    wire signed [18:0] sum;
    reg         [15:0] trimmed;
    reg         [15:0] code_d;

    // Gain plus half scale, then divide by 2^16 by dropping bits (floor)
    assign gain_eff = {1'b0, gain_in} + `DSFCU_GAIN_BIAS;
    assign prod     = {17'h00000, code_in} * {16'h0000, gain_eff};
    assign scaled   = prod[32:16];
    assign sum      = $signed({2'b00, scaled}) + $signed({{3{offset_in[15]}}, offset_in});

    // Saturate so a trim cannot leave the code range
    always @* begin
        if (sum < 0) begin
            trimmed = 16'h0000;
        end else if (sum > $signed(`DSFCU_CODE_MAX)) begin
            trimmed = 16'hffff;
        end else begin
            trimmed = sum[15:0];
        end
    end

    // Clear overrides everything, with no stepping
    always @* begin
        if (clear_in) begin
            code_d = clear_mid_in ? `DSFCU_CLEAR_MID : `DSFCU_CLEAR_ZERO;
        end else if (cal_en_in) begin
            code_d = trimmed;
        end else begin
            code_d = code_in;
        end
    end

    // Registered output
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            code_out <= 16'h0000;
        end else begin
            code_out <= code_d;
        end
    end
endmodule // dsfcu_cal

// ===== design/dsfcu_top.v
`timescale 1ns/1ps

//
// Contract
// - Default frame: address byte, data word
// - Top bit set means read request
// - Readback shifts out MSB first, falling edges
// - Strobe low at frame end: update immediately
// - Strobe high: latches hold while high
// - Strobe falling later updates pending latches
// - Reset holds registers, ignores link, floats output
// - After reset, outputs keep reset values
// - Clear forces zero or midscale per channel
// - Strobe pulses ignored during clear
// - Outputs stay cleared; data registers untouched
// - Clear acts at once, no stepping
// - Enable bit turns on CRC-8 checking
// - Checked frames carry trailing CRC byte
// - Unchecked long frames use last 24 bits
// - Bad CRC: block frame, alarm, error bit
// - Error bit cleared by reset or disable
// - Calibration enabled per channel by bit
// - Output is floor of code times gain plus offset
// - Calibrated code clamped to range ends
// - Shift register commits on frame select rise
// - Extra clocks: only last bits used
//
`include "dsfcu_map.vh"

module dsfcu_top #(
    parameter NCH = 4
) (
    input  wire           clock_in,               // 25 MHz system clock
    input  wire           rst_b_in,               // Hardware reset pin, active low
    input  wire           por_b_in,               // Power-on reset, active low
    input  wire           serial_clock_in,        // Link clock pin
    input  wire           frame_sync_n_in,        // Frame select, active low
    input  wire           serial_data_in,         // Link data in
    input  wire           latch_load_strobe_n_in, // Load strobe, active low
    input  wire           clear_input_in,         // Clear, active high
    output reg            serial_data_out_out,    // Link data out
    output reg            serial_data_out_oe_out, // Link data out enable
    output wire           alarm_n_out,            // Alarm, active low
    output wire [NCH*16-1:0] channel_code_out     // Channel codes, ch0 low
);
    // ****************************************************************
    // Resets and pin synchronisers
    // ****************************************************************
    wire        rst_all_b;
    reg  [4:0]  pin_meta_q;
    reg  [4:0]  pin_sync_q;
    reg  [4:0]  pin_last_q;
    wire [4:0]  pins_raw;

    // Either reset clears the logic; only power-on clears the POWER_ON_CONDITION_BIT bit
    assign rst_all_b = rst_b_in & por_b_in;
    assign pins_raw  = {clear_input_in, latch_load_strobe_n_in, serial_data_in,
                        frame_sync_n_in, serial_clock_in};

    // Two flops per pin, then a third stage used only for edge finding
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            pin_meta_q <= `DSFCU_PIN_IDLE;
            pin_sync_q <= `DSFCU_PIN_IDLE;
            pin_last_q <= `DSFCU_PIN_IDLE;
        end else begin
            pin_meta_q <= pins_raw;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end

    wire sclk_fall    = pin_last_q[0] & ~pin_sync_q[0];
    wire sync_rise    = ~pin_last_q[1] & pin_sync_q[1];
    wire sync_fall    = pin_last_q[1] & ~pin_sync_q[1];
    wire frame_active = ~pin_sync_q[1];
    wire serial_data_in_s       = pin_sync_q[2];
    wire latch_load_strobe_n_n_s     = pin_sync_q[3];
    wire latch_load_strobe_n_fall    = pin_last_q[3] & ~pin_sync_q[3];
    wire clr_s        = pin_sync_q[4];

    // ****************************************************************
    // Shift register and bit count
    // ****************************************************************
    reg  [31:0]             shift_q;
    reg  [`DSFCU_CNT_W-1:0] cnt_q;

    // Count saturates; older bits simply fall off the top
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            shift_q <= 32'h00000000;
            cnt_q   <= {`DSFCU_CNT_W{1'b0}};
        end else if (sync_fall) begin
            cnt_q   <= {`DSFCU_CNT_W{1'b0}};
        end else if (frame_active && sclk_fall) begin
            shift_q <= {shift_q[30:0], serial_data_in_s};
            if (cnt_q != `DSFCU_CRC_FRAME_BITS) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Frame decode and CRC check
    // ****************************************************************
    reg  [15:0] select_q;
    wire [7:0]  rx_rem;
    wire        crc_en   = select_q[`DSFCU_CRC_CHECK_ENABLE_BIT];
    wire        long_ok  = (cnt_q >= `DSFCU_CRC_FRAME_BITS);
    wire        short_ok = (cnt_q >= `DSFCU_FRAME_BITS);
    wire        crc_ok   = (rx_rem == 8'h00);

    dsfcu_crc8 #(.DW(32)) u_rx_crc (
        .data_in (shift_q),
        .crc_out (rx_rem)
    );

    // Checked frames keep the CRC low; unchecked keep only the last 24 bits
    wire [23:0] frame  = crc_en ? shift_q[31:8] : shift_q[23:0];
    wire        take   = sync_rise & (crc_en ? (long_ok & crc_ok) : short_ok);
    wire        crc_bad = sync_rise & crc_en & long_ok & ~crc_ok;
    wire        is_read = frame[`DSFCU_RW_BIT];
    wire [6:0]  addr    = frame[`DSFCU_ADDR_MSB:`DSFCU_ADDR_LSB];
    wire [15:0] wdata   = frame[`DSFCU_DATA_MSB:0];
    wire        wr      = take & ~is_read;
    wire        rd      = take & is_read;
    wire [NCH-1:0] sel_mask = select_q[`DSFCU_CH_LSB+NCH-1:`DSFCU_CH_LSB];

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg  [15:0]    config_q [0:NCH-1];
    reg  [15:0]    data_q   [0:NCH-1];
    reg  [15:0]    gain_q   [0:NCH-1];
    reg  [15:0]    offset_q [0:NCH-1];
    reg  [NCH-1:0] calen_q;
    reg            poc_q;
    reg            sw_rst_q;
    reg            cre_q;
    integer        i, j, k;

    // Power-on condition survives the hardware reset pin
    always @(posedge clock_in or negedge por_b_in) begin
        if (!por_b_in) begin
            poc_q <= 1'b0;
        end else if (wr && addr == `DSFCU_ADDR_RSTCFG) begin
            poc_q <= wdata[`DSFCU_POC_BIT];
        end
    end

    // Software reset acts one cycle after the frame that asks for it
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= wr && (addr == `DSFCU_ADDR_RESET) && wdata[`DSFCU_SW_RST_BIT];
        end
    end

    // Error flag: set wins; drops on reset or when checking goes off
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            cre_q <= 1'b0;
        end else if (crc_bad) begin
            cre_q <= 1'b1;
        end else if (sw_rst_q || !crc_en) begin
            cre_q <= 1'b0;
        end
    end

    assign alarm_n_out = ~cre_q;

    // Writes hit every selected channel at once
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            select_q <= 16'h0000;
            calen_q  <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                config_q[i] <= 16'h0000;
                data_q[i]   <= 16'h0000;
                gain_q[i]   <= `DSFCU_GAIN_RST;
                offset_q[i] <= 16'h0000;
            end
        end else if (sw_rst_q) begin
            select_q <= 16'h0000;
            calen_q  <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                config_q[i] <= 16'h0000;
                data_q[i]   <= 16'h0000;
                gain_q[i]   <= `DSFCU_GAIN_RST;
                offset_q[i] <= 16'h0000;
            end
        end else if (wr) begin
            if (addr == `DSFCU_ADDR_SELECT) begin
                select_q <= wdata & `DSFCU_SELECT_MASK;
            end
            for (i = 0; i < NCH; i = i + 1) begin
                if (sel_mask[i]) begin
                    case (addr)
                        `DSFCU_ADDR_CONFIG: config_q[i] <= wdata;
                        `DSFCU_ADDR_DATA:   data_q[i]   <= wdata;
                        `DSFCU_ADDR_CALEN:  calen_q[i]  <= wdata[`DSFCU_CALEN_BIT];
                        `DSFCU_ADDR_GAIN:   gain_q[i]   <= wdata;
                        `DSFCU_ADDR_OFFSET: offset_q[i] <= wdata;
                        default:            calen_q[i]  <= calen_q[i];
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Latch update and clear
    // ****************************************************************
    reg  [15:0]    latch_q [0:NCH-1];
    reg  [NCH-1:0] pending_q;
    reg  [NCH-1:0] cleared_q;
    reg  [NCH-1:0] upd;
    wire           data_wr = wr && (addr == `DSFCU_ADDR_DATA);

    // Strobe sampled at the frame end picks immediate or deferred update
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            pending_q <= {NCH{1'b0}};
            upd       <= {NCH{1'b0}};
            for (j = 0; j < NCH; j = j + 1) begin
                latch_q[j] <= 16'h0000;
            end
        end else if (sw_rst_q) begin
            pending_q <= {NCH{1'b0}};
            upd       <= {NCH{1'b0}};
            for (j = 0; j < NCH; j = j + 1) begin
                latch_q[j] <= 16'h0000;
            end
        end else begin
            upd <= {NCH{1'b0}};
            // Deferred copy from the input registers; blocked during clear
            if (latch_load_strobe_n_fall && !clr_s) begin
                for (j = 0; j < NCH; j = j + 1) begin
                    if (pending_q[j]) begin
                        latch_q[j] <= data_q[j];
                    end
                end
                upd       <= pending_q;
                pending_q <= {NCH{1'b0}};
            end
            if (data_wr) begin
                for (j = 0; j < NCH; j = j + 1) begin
                    if (sel_mask[j]) begin
                        if (!latch_load_strobe_n_n_s) begin
                            latch_q[j]   <= wdata;
                            upd[j]       <= 1'b1;
                            pending_q[j] <= 1'b0;
                        end else begin
                            pending_q[j] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Clear is sticky until fresh data lands; set wins over release
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            cleared_q <= {NCH{1'b0}};
        end else if (clr_s) begin
            cleared_q <= {NCH{1'b1}};
        end else begin
            cleared_q <= cleared_q & ~upd;
        end
    end

    // One trim stage per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            dsfcu_cal u_cal (
                .clock_in     (clock_in),
                .rst_b_in     (rst_all_b),
                .code_in      (latch_q[g]),
                .gain_in      (gain_q[g]),
                .offset_in    (offset_q[g]),
                .cal_en_in    (calen_q[g]),
                .clear_in     (cleared_q[g]),
                .clear_mid_in (select_q[`DSFCU_CLSL_LSB+g]),
                .code_out     (channel_code_out[g*16+15:g*16])
            );
        end
    endgenerate

    // ****************************************************************
    // Readback
    // ****************************************************************
    reg  [6:0]  rd_addr_q;
    reg         rd_pend_q;
    reg  [31:0] tx_q;
    reg  [15:0] rd_val;
    reg  [1:0]  rd_ch;
    wire [23:0] tx_frame = {1'b0, rd_addr_q, rd_val};
    wire [7:0]  tx_crc;

    dsfcu_crc8 #(.DW(24)) u_tx_crc (
        .data_in (tx_frame),
        .crc_out (tx_crc)
    );

    // Lowest selected channel answers per-channel reads
    always @* begin
        rd_ch = 2'd0;
        for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (sel_mask[k]) begin
                rd_ch = k[1:0];
            end
        end
    end

    // Unmapped and write-only addresses read as zero
    always @* begin
        case (rd_addr_q)
            `DSFCU_ADDR_RSTCFG: rd_val = {15'h0000, poc_q} << `DSFCU_POC_BIT;
            `DSFCU_ADDR_SELECT: rd_val = select_q;
            `DSFCU_ADDR_CONFIG: rd_val = config_q[rd_ch];
            `DSFCU_ADDR_DATA:   rd_val = data_q[rd_ch];
            `DSFCU_ADDR_CALEN:  rd_val = {15'h0000, calen_q[rd_ch]};
            `DSFCU_ADDR_GAIN:   rd_val = gain_q[rd_ch];
            `DSFCU_ADDR_OFFSET: rd_val = offset_q[rd_ch];
            `DSFCU_ADDR_STATUS: rd_val = {15'h0000, cre_q} << `DSFCU_CRE_BIT;
            default:            rd_val = 16'h0000;
        endcase
    end

    // Pointer moves only on a read frame that passed all checks
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            rd_addr_q <= `DSFCU_ADDR_NOP;
            rd_pend_q <= 1'b0;
        end else if (rd) begin
            rd_addr_q <= addr;
            rd_pend_q <= 1'b1;
        end else if (sync_fall) begin
            rd_pend_q <= 1'b0;
        end
    end

    // Value is sampled at the next frame start, then shifted out
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            tx_q <= 32'h00000000;
        end else if (sync_fall) begin
            if (rd_pend_q) begin
                tx_q <= {tx_frame, crc_en ? tx_crc : 8'h00};
            end else begin
                tx_q <= 32'h00000000;
            end
        end else if (frame_active && sclk_fall) begin
            tx_q <= {tx_q[30:0], 1'b0};
        end
    end

    // Output floats outside frames and in reset
    always @(posedge clock_in or negedge rst_all_b) begin
        if (!rst_all_b) begin
            serial_data_out_out    <= 1'b0;
            serial_data_out_oe_out <= 1'b0;
        end else begin
            serial_data_out_out    <= tx_q[31];
            serial_data_out_oe_out <= frame_active;
        end
    end
endmodule // dsfcu_top

// ===== tb/dsfcu_chk.sv
`timescale 1ns/1ps
// ****
// Pin-level checks
// ****
module dsfcu_chk #(parameter NCH = 4) (
    input wire logic clock_in, rst_b_in, por_b_in, serial_clock_in, frame_sync_n_in,
    input wire logic latch_load_strobe_n_in, clear_input_in, serial_data_out_out,
    input wire logic serial_data_out_oe_out, alarm_n_out,
    input wire logic [NCH*16-1:0] channel_code_out);
    default clocking @(posedge clock_in); endclocking
    // Either reset masks everything, they are ORed inside
    default disable iff (!rst_b_in || !por_b_in);
    rst_values_a: assert property ($rose(rst_b_in & por_b_in) |-> alarm_n_out
        && !serial_data_out_oe_out && channel_code_out == 0) else $error("Reset values lost");
    sdo_float_a: assert property (frame_sync_n_in [*5] |-> !serial_data_out_oe_out)
        else $error("Output driven while idle");
    sdo_drive_a: assert property (!frame_sync_n_in [*5] |-> serial_data_out_oe_out)
        else $error("Output not driven in frame");
    sdo_steady_a: assert property ((serial_clock_in && !frame_sync_n_in) [*6]
        |-> $stable(serial_data_out_out)) else $error("Output moved without a fall");
    code_hold_a: assert property ((latch_load_strobe_n_in && !frame_sync_n_in
        && !clear_input_in) [*8] |-> $stable(channel_code_out)) else $error("Codes moved");
    clear_code_a: assert property (clear_input_in [*6]
        |-> (channel_code_out & {NCH{16'h7fff}}) == 0) else $error("Codes not cleared");
    alarm_set_a: assert property ($fell(alarm_n_out) |-> frame_sync_n_in
        && $past(frame_sync_n_in, 2)) else $error("Alarm outside commit");
    alarm_clear_a: assert property ($rose(alarm_n_out) |-> frame_sync_n_in
        && $past(frame_sync_n_in, 2)) else $error("Alarm released outside commit");
endmodule // dsfcu_chk
bind dsfcu_top dsfcu_chk #(.NCH(NCH)) u_chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .por_b_in(por_b_in), .serial_clock_in(serial_clock_in), .frame_sync_n_in(frame_sync_n_in),
    .latch_load_strobe_n_in(latch_load_strobe_n_in), .clear_input_in(clear_input_in),
    .serial_data_out_out(serial_data_out_out), .serial_data_out_oe_out(serial_data_out_oe_out),
    .alarm_n_out(alarm_n_out), .channel_code_out(channel_code_out));

// ===== tb/dsfcu_host.sv
`timescale 1ns/1ps
// ****
// Host controller model
// ****
module dsfcu_host (
    input  wire logic clock_in,   // System clock
    input  wire logic sdo_in,     // Readback bit
    output logic      sclk_out,   // Link clock, idles high
    output logic      sync_n_out, // Frame select
    output logic      sdi_out);   // Link data
    initial begin
        sclk_out = 1;
        sync_n_out = 1;
        sdi_out = 0;
    end
    // One frame, MSB first, 320 ns link period; readback taken before each fall
    task automatic xfer(input logic [31:0] f, input int n, output logic [31:0] rx);
        rx = 0;
        @(posedge clock_in) #1 sync_n_out = 0;
        repeat (3) @(posedge clock_in);
        // Every pin moves 1 ns after an edge; readback taken off the edge
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clock_in) #1 sclk_out = 1;
            sdi_out = f[i];
            repeat (4) @(posedge clock_in);
            #1 rx = {rx[30:0], sdo_in};
            sclk_out = 0;
            repeat (3) @(posedge clock_in);
        end
        @(posedge clock_in) #1 sclk_out = 1;
        sdi_out = ~sdi_out;                    // Released line never shows a stale bit
        sync_n_out = 1;
        repeat (12) @(posedge clock_in);       // Commit and code update land meanwhile
        #1;
    endtask
endmodule // dsfcu_host

// ===== tb/dsfcu_top_bench.sv
`timescale 1ns/1ps
// ****
// Frame, latch and clear bench
// ****
module dsfcu_top_bench;
    logic clock_in, rst_b_in, por_b_in, strobe_n, clear, sclk, sync_n, sdi, serial_data_out, oe, alarm_n;
    logic [63:0] codes;
    logic [15:0] sel, d;
    logic [31:0] rx;
    logic        crc_on = 0, calen = 0, clrf = 0;
    longint      lat = 0, gain = 32768, off = 0;
    int          fails = 0, num_checks = 0, seed = 41471;
    dsfcu_top #(.NCH(4)) u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in),
        .serial_clock_in(sclk), .frame_sync_n_in(sync_n), .serial_data_in(sdi),
        .latch_load_strobe_n_in(strobe_n), .clear_input_in(clear), .serial_data_out_out(serial_data_out),
        .serial_data_out_oe_out(oe), .alarm_n_out(alarm_n), .channel_code_out(codes));
    dsfcu_host u_host (.clock_in(clock_in), .sdo_in(serial_data_out), .sclk_out(sclk),
        .sync_n_out(sync_n), .sdi_out(sdi));
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    function automatic logic [7:0] crc8(input logic [23:0] w);
        logic [7:0] c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic send(input logic [23:0] w, input logic bad = 0);
        if (crc_on) u_host.xfer({w, crc8(w) ^ {7'h00, bad}}, 32, rx);
        else u_host.xfer({8'h00, w}, 24, rx);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        send({1'b1, a, 16'h0000});
        send(24'h000000);
        chk("readback", crc_on ? {1'b0, a, e, crc8({1'b0, a, e})}
            : {8'h00, 1'b0, a, e}, rx);
    endtask
    // Expected channel codes from the trim formula and clear state
    task automatic cc;
        longint v;
        v = calen ? lat * (gain + 32768) / 65536 + off : lat;
        v = v < 0 ? 0 : (v > 65535 ? 65535 : v);
        for (int i = 0; i < 4; i++)
            chk("code", clrf ? {sel[9+i], 15'h0000} : v[15:0], codes[16*i+:16]);
    endtask
    initial begin
        clock_in = 0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #2000000;
        fails++;
        stop_test;
    end
    // Main sequence; all four channels selected, except after the soft and hardware resets
    initial begin
        {rst_b_in, por_b_in, strobe_n, clear} = 4'h0;
        sel = 16'h0000;
        cyc(16);
        {rst_b_in, por_b_in} = 2'h3;
        cyc(4);
        cc;
        rd(7'h09, 16'h8000);
        rd(7'h08, 16'h0000);
        sel = 16'h01e0 | ($random(seed) & 16'h1e00);
        send({8'h03, sel});
        for (int k = 0; k < 3; k++) begin
            d = $random(seed);
            send({8'h05, d});
            lat = d;
            cc;
        end
        strobe_n = 1;
        d = $random(seed);
        send({8'h05, d});
        cyc(20);
        cc;
        strobe_n = 0;
        lat = d;
        cyc(10);
        cc;
        clear = 1;
        clrf = 1;
        cyc(10);
        cc;
        strobe_n = 1;
        d = $random(seed);
        send({8'h05, d});
        strobe_n = 0;
        cyc(10);
        cc;
        clear = 0;
        cyc(10);
        cc;
        rd(7'h05, d);
        gain = $random(seed) & 16'hffff;
        d = $random(seed);
        off = $signed(d);
        send({8'h09, gain[15:0]});
        send({8'h0a, d});
        send({8'h08, 16'h0001});
        calen = 1;
        rd(7'h09, gain[15:0]);
        for (int k = 0; k < 4; k++) begin
            d = k == 0 ? 16'hffff : (k == 1 ? 16'h0000 : $random(seed));
            send({8'h05, d});
            lat = d;
            clrf = 0;
            cc;
        end
        sel = sel | 16'h0008;
        send({8'h03, sel});
        crc_on = 1;
        d = $random(seed);
        send({8'h05, d}, 1);
        chk("alarm", 0, alarm_n);
        cc;
        rd(7'h0b, 16'h0020);
        send({8'h89, 16'h0000}, 1);
        send(24'h000000);
        chk("dropped read", 0, rx);
        sel = sel & 16'hfff7;
        send({8'h03, sel});
        crc_on = 0;
        chk("alarm", 1, alarm_n);
        u_host.xfer({d[7:0], 8'h05, d}, 32, rx);
        lat = d;
        cc;
        // Soft reset, then a hardware reset in mid-run; POWER_ON_CONDITION_BIT must survive both
        send({8'h02, 16'h0002});
        send({8'h01, 16'h0001});
        lat = 0;
        calen = 0;
        cc;
        rd(7'h09, 16'h8000);
        send({8'h03, 16'h01e0});
        d = $random(seed);
        send({8'h05, d});
        rst_b_in = 0;
        cyc(3);
        rst_b_in = 1;
        cyc(4);
        cc;
        rd(7'h03, 16'h0000);
        rd(7'h02, 16'h0002);
        stop_test;
    end
endmodule // dsfcu_top_bench
